// ===== hdl/capture_pkg.sv
// Shared constants and carrier types for the input capture channel.
// Assumes a single clock domain and a 16-bit channel control word.
package capture_pkg;

   // ---------------------------------------------------------------
   // Buffer geometry
   // ---------------------------------------------------------------
   localparam int unsigned WORD_W     = 16;
   localparam int unsigned FIFO_DEPTH = 4;
   localparam int unsigned LEVEL_W    = 3;
   localparam logic [2:0]  LEVEL_FULL = 3'h4;
   localparam logic [2:0]  LEVEL_ZERO = 3'h0;

   // ---------------------------------------------------------------
   // Control word field positions and reset value
   // ---------------------------------------------------------------
   localparam int unsigned MODE_LO   = 0;
   localparam int unsigned MODE_HI   = 2;
   localparam int unsigned EPI_LO    = 5;
   localparam int unsigned EPI_HI    = 6;
   localparam int unsigned TSEL_BIT  = 7;
   localparam int unsigned SIDL_BIT  = 13;
   // Timebase select set: time_base_three is the source out of reset
   localparam logic [15:0] CTRL_RESET = 16'h0080;

   // ---------------------------------------------------------------
   // Capture modes and prescale terminal counts
   // ---------------------------------------------------------------
   localparam logic [2:0] MODE_OFF      = 3'h0;
   localparam logic [2:0] MODE_EVERY    = 3'h1;
   localparam logic [2:0] MODE_FALL     = 3'h2;
   localparam logic [2:0] MODE_RISE     = 3'h3;
   localparam logic [2:0] MODE_RISE4    = 3'h4;
   localparam logic [2:0] MODE_RISE16   = 3'h5;
   localparam logic [2:0] MODE_INT_ONLY = 3'h7;
   localparam logic [3:0] PRE4_LAST     = 4'h3;
   localparam logic [3:0] PRE16_LAST    = 4'hF;

   // Power state of the surrounding core
   typedef struct packed {
      logic sleep;
      logic idle;
   } power_t;

   // Status bits seen by software
   typedef struct packed {
      logic fifo_not_empty;
      logic capture_overflow;
      logic channel_irq_flag;
   } status_t;

endpackage

// ===== hdl/capture_fifo.sv
// Four-word shift buffer for captured timebase values.
// Assumes the caller never pushes when full unless it pops in the same cycle.
`timescale 1ns/1ps
module capture_fifo
   import capture_pkg::*;
(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst_n,
   // Write side
   input  wire logic              push,
   input  wire logic [WORD_W-1:0] push_data,
   // Read side
   input  wire logic              pop,
   output logic      [WORD_W-1:0] head,
   output logic      [LEVEL_W-1:0] level,
   output logic      [LEVEL_W-1:0] level_next
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [FIFO_DEPTH-1:0][WORD_W-1:0] words;
      logic [LEVEL_W-1:0]                count;
   } fifo_st_t;

   fifo_st_t st_reg;
   fifo_st_t st_next;

   // Slot 0 always holds the oldest word, so a pop shifts all forward
   always_comb begin
      logic [LEVEL_W-1:0] wr_idx;
      wr_idx  = st_reg.count;
      st_next = st_reg;
      if (pop && st_reg.count != LEVEL_ZERO) begin
         for (int i = 0; i < FIFO_DEPTH - 1; i++) begin
            st_next.words[i] = st_reg.words[i+1];
         end
         wr_idx        = st_reg.count - 3'h1;
         st_next.count = wr_idx;
      end
      if (push && wr_idx < LEVEL_FULL) begin
         st_next.words[wr_idx[1:0]] = push_data;
         st_next.count              = wr_idx + 3'h1;
      end
   end

   // Register the whole state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign head       = st_reg.words[0];
   assign level      = st_reg.count;
   assign level_next = st_next.count;

endmodule // capture_fifo

// ===== hdl/input_capture_channel.sv
// One input capture channel: pin edge detection, prescale, timebase capture
// into a four-word buffer, overflow, event counting and wake-up.
// Assumes the pin is asynchronous and the timebases run on MCLK.
`timescale 1ns/1ps
module input_capture_channel
   import capture_pkg::*;
(
   // Clock and reset
   input  wire logic              MCLK,
   input  wire logic              RST_N,
   // Capture pin
   input  wire logic              CAP_PIN,
   // Timebases
   input  wire logic [WORD_W-1:0] TB2_VALUE,
   input  wire logic              TB2_RUN,
   input  wire logic [WORD_W-1:0] TB3_VALUE,
   input  wire logic              TB3_RUN,
   // Core power state
   input  wire power_t            POWER,
   // Control word write
   input  wire logic              CTRL_WE,
   input  wire logic [15:0]       CTRL_WDATA,
   output logic      [15:0]       CTRL_Q,
   // Buffer read
   input  wire logic              FIFO_RD,
   output logic      [WORD_W-1:0] CAP_DATA,
   // Interrupt control
   input  wire logic              IRQ_ENABLE,
   input  wire logic              IRQ_FLAG_CLR,
   // Status and requests
   output status_t                STATUS,
   output logic                   IRQ_REQ,
   output logic                   WAKE
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [2:0]        sync;
      logic              pin_lvl;
      logic [15:0]       ctrl;
      logic [3:0]        pre_cnt;
      logic [1:0]        evt_cnt;
      logic              block;
      status_t           stat;
      logic              irq_req;
      logic              wake;
      logic [WORD_W-1:0] rd_data;
   } chan_st_t;

   chan_st_t st_reg;
   chan_st_t st_next;

   logic               push;
   logic [WORD_W-1:0]  push_data;
   logic               pop;
   logic [WORD_W-1:0]  head;
   logic [LEVEL_W-1:0] level;
   logic [LEVEL_W-1:0] level_next;

   logic [2:0]         mode;
   logic [1:0]         epi;
   logic               tsel;
   logic               sidl;
   logic               rise;
   logic               fall;
   logic               timer_run;
   logic               active;
   logic               hit;
   logic               int_only;
   logic               settled;

   // ---------------------------------------------------------------
   // Decoded control and pin edges
   // ---------------------------------------------------------------
   // A pin change counts once stages two and three agree; stage one may be metastable
   // The filtered level resets low, so a pin that idles high shows one rise after reset
   assign mode      = st_reg.ctrl[MODE_HI:MODE_LO];
   assign epi       = st_reg.ctrl[EPI_HI:EPI_LO];
   assign tsel      = st_reg.ctrl[TSEL_BIT];
   assign sidl      = st_reg.ctrl[SIDL_BIT];
   assign settled   = (st_reg.sync[1] == st_reg.sync[2]);
   assign rise      = settled & st_reg.sync[2] & ~st_reg.pin_lvl;
   assign fall      = settled & ~st_reg.sync[2] & st_reg.pin_lvl;
   assign timer_run = tsel ? TB3_RUN : TB2_RUN;
   assign push_data = tsel ? TB3_VALUE : TB2_VALUE;

   // Capturing modes run in normal state, in idle only with a live timer and SIDL clear, never in sleep
   assign active = POWER.sleep ? 1'b0 :
                   POWER.idle  ? (timer_run & ~sidl) : 1'b1;

   // Interrupt-only mode ignores timers entirely, and power state except for WAKE
   assign int_only = (mode == MODE_INT_ONLY) & rise;

   // Qualified capture edge per mode
   always_comb begin
      case (mode)
         MODE_EVERY:  hit = rise | fall;
         MODE_FALL:   hit = fall;
         MODE_RISE:   hit = rise;
         MODE_RISE4:  hit = rise & (st_reg.pre_cnt[1:0] == PRE4_LAST[1:0]);
         MODE_RISE16: hit = rise & (st_reg.pre_cnt == PRE16_LAST);
         default:     hit = 1'b0;
      endcase
   end

   // Reading an empty buffer leaves CAP_DATA unchanged; the reader avoids it
   assign pop  = FIFO_RD & (level != LEVEL_ZERO);

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      logic cap;
      logic room;
      logic set_flag;
      logic set_ovf;
      cap      = active & hit & ~st_reg.block;
      room     = (level < LEVEL_FULL) | pop;
      set_flag = 1'b0;
      set_ovf  = 1'b0;
      push     = 1'b0;
      st_next  = st_reg;
      st_next.sync = {st_reg.sync[1:0], CAP_PIN};

      // Filtered pin level follows only once the two late stages agree
      if (settled) begin
         st_next.pin_lvl = st_reg.sync[2];
      end

      // Edge prescaler counts rising edges in the divided modes
      if (active && rise && (mode == MODE_RISE4 || mode == MODE_RISE16)) begin
         st_next.pre_cnt = (hit) ? 4'h0 : st_reg.pre_cnt + 4'h1;
      end

      // Store, drop or overflow
      if (cap) begin
         if (mode == MODE_EVERY) begin
            push     = room;
            set_flag = 1'b1;
         end else if (room) begin
            push = 1'b1;
            // Event counter ends after epi plus one stored captures
            if (st_reg.evt_cnt == epi) begin
               set_flag        = 1'b1;
               st_next.evt_cnt = 2'h0;
            end else begin
               st_next.evt_cnt = st_reg.evt_cnt + 2'h1;
            end
         end else begin
            set_ovf = 1'b1;
         end
      end
      if (int_only) begin
         set_flag = 1'b1;
      end

      // Blocking lasts until the last stored word has been read
      if (set_ovf) begin
         st_next.block = 1'b1;
      end else if (level_next == LEVEL_ZERO) begin
         st_next.block = 1'b0;
      end

      // Control write clears the counters; mode off also clears overflow
      if (CTRL_WE) begin
         st_next.ctrl    = CTRL_WDATA;
         st_next.pre_cnt = 4'h0;
         st_next.evt_cnt = 2'h0;
         if (CTRL_WDATA[MODE_HI:MODE_LO] == MODE_OFF) begin
            st_next.stat.capture_overflow = 1'b0;
         end
      end
      // Set wins over clear so no overflow is missed
      if (set_ovf) begin
         st_next.stat.capture_overflow = 1'b1;
      end

      // Interrupt flag: software clear loses to a same-cycle event
      if (IRQ_FLAG_CLR) begin
         st_next.stat.channel_irq_flag = 1'b0;
      end
      if (set_flag) begin
         st_next.stat.channel_irq_flag = 1'b1;
      end
      st_next.irq_req = st_next.stat.channel_irq_flag & IRQ_ENABLE;

      // Wake needs no timer; only the interrupt-only edge, the enable and sleep or idle
      st_next.wake = int_only & IRQ_ENABLE & (POWER.sleep | POWER.idle);

      // Read returns the oldest word and the not-empty flag follows the new level
      if (pop) begin
         st_next.rd_data = head;
      end
      st_next.stat.fifo_not_empty = (level_next != LEVEL_ZERO);
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         st_reg      <= '0;
         st_reg.ctrl <= CTRL_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   // ---------------------------------------------------------------
   // Capture buffer
   // ---------------------------------------------------------------
   capture_fifo u_fifo (
      .clk        (MCLK),
      .rst_n      (RST_N),
      .push       (push),
      .push_data  (push_data),
      .pop        (pop),
      .head       (head),
      .level      (level),
      .level_next (level_next)
   );

   // Outputs straight from the state register
   assign CTRL_Q   = st_reg.ctrl;
   assign CAP_DATA = st_reg.rd_data;
   assign STATUS   = st_reg.stat;
   assign IRQ_REQ  = st_reg.irq_req;
   assign WAKE     = st_reg.wake;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_N);

   AST_LEVEL_BOUND: assert property (level <= LEVEL_FULL)
      else $error("buffer level above four");

   AST_NOT_EMPTY: assert property (STATUS.fifo_not_empty == (level != LEVEL_ZERO))
      else $error("not-empty flag disagrees with level");

   AST_READ_OLDEST: assert property (pop |=> CAP_DATA == $past(head))
      else $error("read did not return oldest word");

   AST_OVF_CAUSE: assert property ($rose(STATUS.capture_overflow) |-> $past(level) == LEVEL_FULL)
      else $error("overflow set while buffer not full");

   AST_BLOCK_NO_PUSH: assert property (st_reg.block |-> !push)
      else $error("capture stored while blocked");

   AST_TSEL_SRC: assert property (push && tsel |-> push_data == TB3_VALUE)
      else $error("wrong timebase captured");

   AST_EVERY_FLAG: assert property (mode == MODE_EVERY && active && (rise || fall) && !st_reg.block
                                    |=> STATUS.channel_irq_flag)
      else $error("every-edge mode missed a flag");

   AST_EVERY_NO_OVF: assert property (mode == MODE_EVERY && !STATUS.capture_overflow
                                      |=> !STATUS.capture_overflow)
      else $error("overflow raised in every-edge mode");

   AST_WAKE_SRC: assert property (WAKE |-> $past(mode) == MODE_INT_ONLY && $past(IRQ_ENABLE))
      else $error("wake without interrupt-only mode and enable");

   AST_SLEEP_NO_PUSH: assert property (POWER.sleep |-> !push)
      else $error("capture stored in sleep");

   AST_IDLE_GATE: assert property (POWER.idle && (sidl || !timer_run) |-> !push)
      else $error("capture stored in idle without timer");

   AST_EPI_FLAG: assert property (push && mode != MODE_EVERY && st_reg.evt_cnt == epi && !CTRL_WE
                                  |=> STATUS.channel_irq_flag && st_reg.evt_cnt == 2'h0)
      else $error("event count reached without flag");

   AST_REQ_PAIR: assert property (IRQ_REQ == (STATUS.channel_irq_flag && $past(IRQ_ENABLE)))
      else $error("request not flag and enable");

   AST_FLAG_STICKY: assert property (STATUS.channel_irq_flag && !IRQ_FLAG_CLR
                                     |=> STATUS.channel_irq_flag)
      else $error("flag cleared without software");

   // Modes that store nothing must never push
   AST_OFF_NO_PUSH: assert property (mode == MODE_OFF |-> !push)
      else $error("capture stored with mode off");

   AST_INT_ONLY_NO_PUSH: assert property (mode == MODE_INT_ONLY |-> !push)
      else $error("capture stored in interrupt-only mode");

   AST_OVF_DROP: assert property (level == LEVEL_FULL && !pop |-> !push)
      else $error("word pushed into a full buffer");

   AST_OVF_STICKY: assert property (STATUS.capture_overflow && !CTRL_WE |=> STATUS.capture_overflow)
      else $error("overflow cleared without a control write");

   AST_BLOCK_HOLD: assert property (st_reg.block && level_next != LEVEL_ZERO |=> st_reg.block)
      else $error("capture unblocked before buffer drained");

   AST_SLEEP_FLAG_SRC: assert property (
      POWER.sleep && mode != MODE_INT_ONLY && !STATUS.channel_irq_flag |=> !STATUS.channel_irq_flag)
      else $error("flag raised in sleep outside interrupt-only mode");

   AST_INT_ONLY_FLAG: assert property (int_only |=> STATUS.channel_irq_flag)
      else $error("interrupt-only edge did not set the flag");

   AST_SLEEP_NO_PRESCALE: assert property (POWER.sleep && !CTRL_WE |=> $stable(st_reg.pre_cnt))
      else $error("edge prescaler moved in sleep");

   AST_SLEEP_NO_EVT: assert property (POWER.sleep && !CTRL_WE |=> $stable(st_reg.evt_cnt))
      else $error("event counter moved in sleep");

   AST_PRESCALE_RANGE: assert property (mode == MODE_RISE4 |-> st_reg.pre_cnt <= PRE4_LAST)
      else $error("divide-by-four prescaler out of range");

   AST_REQ_NEEDS_FLAG: assert property (IRQ_REQ |-> STATUS.channel_irq_flag)
      else $error("request without flag");

   AST_EPI_SILENT: assert property (
      push && mode != MODE_EVERY && st_reg.evt_cnt != epi && !STATUS.channel_irq_flag
      |=> !STATUS.channel_irq_flag)
      else $error("flag raised before the programmed event count");

   AST_WAKE_PULSE: assert property (WAKE |=> !WAKE)
      else $error("wake held longer than one cycle");

endmodule // input_capture_channel

// ===== verification/capture_pin_source.sv
// Behavioural model of the external signal that drives the capture pin.
// Assumes the bench calls its tasks from one thread, clocked by MCLK.
`timescale 1ns/1ps
module capture_pin_source (
   // Clock
   input  wire logic MCLK,
   // Pin
   output logic      PIN
);
   // ---------------------------------------------------------------
   // Pin driving
   // ---------------------------------------------------------------
   initial PIN = 1'b0;

   // Change just after an edge, then hold; a slow source holds longer
   task automatic drive(input logic level, input int hold);
      @(posedge MCLK);
      PIN <= level;
      repeat (hold) @(posedge MCLK);
   endtask

   // One high phase then one low phase, each long enough for the synchroniser
   task automatic pulse(input int hold);
      drive(1'b1, hold);
      drive(1'b0, hold);
   endtask
endmodule // capture_pin_source

// ===== verification/tb_top.sv
// Self-checking bench for the input capture channel.
// Assumes the capture package and the pin source model are compiled first.
`timescale 1ns/1ps
module tb_top
   import capture_pkg::*;
();
   // ---------------------------------------------------------------
   // Stimulus and observation
   // ---------------------------------------------------------------
   logic        mclk = 1'b0;
   logic        rst_n = 1'b0;
   logic        cap_pin;
   logic [15:0] tb2_value = 16'h0000;
   logic [15:0] tb3_value = 16'h0000;
   logic        tb2_run = 1'b1;
   logic        tb3_run = 1'b1;
   power_t      power = '{1'b0, 1'b0};
   logic        ctrl_we = 1'b0;
   logic [15:0] ctrl_wdata = 16'h0000;
   logic [15:0] ctrl_q;
   logic        fifo_rd = 1'b0;
   logic [15:0] cap_data;
   logic        irq_en = 1'b0;
   logic        irq_clr = 1'b0;
   status_t     status;
   logic        irq_req;
   logic        wake;
   logic        wake_seen = 1'b0;
   int          failures = 0;
   int          tests_run = 0;

   always #2 mclk = ~mclk;

   // Wake is a one-cycle pulse, so it is latched for later inspection
   always @(posedge mclk) if (wake === 1'b1) wake_seen <= 1'b1;

   capture_pin_source i_capture_pin_source (.MCLK(mclk), .PIN(cap_pin));

   input_capture_channel i_input_capture_channel (
      .MCLK(mclk), .RST_N(rst_n), .CAP_PIN(cap_pin),
      .TB2_VALUE(tb2_value), .TB2_RUN(tb2_run), .TB3_VALUE(tb3_value), .TB3_RUN(tb3_run),
      .POWER(power), .CTRL_WE(ctrl_we), .CTRL_WDATA(ctrl_wdata), .CTRL_Q(ctrl_q),
      .FIFO_RD(fifo_rd), .CAP_DATA(cap_data), .IRQ_ENABLE(irq_en), .IRQ_FLAG_CLR(irq_clr),
      .STATUS(status), .IRQ_REQ(irq_req), .WAKE(wake));

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [15:0] v);
      @(posedge mclk) begin ctrl_we <= 1'b1; ctrl_wdata <= v; end
      @(posedge mclk) ctrl_we <= 1'b0;
      @(posedge mclk) #1;
   endtask

   task automatic rd(input logic [15:0] exp);
      @(posedge mclk) fifo_rd <= 1'b1;
      @(posedge mclk) fifo_rd <= 1'b0;
      @(posedge mclk) #1;
      check(cap_data, exp);
   endtask

   task automatic clr();
      @(posedge mclk) irq_clr <= 1'b1;
      @(posedge mclk) irq_clr <= 1'b0;
      @(posedge mclk) #1;
      wake_seen = 1'b0;
   endtask

   // Pulses, then waits out the fixed synchroniser and detect latency
   task automatic rise(input int n);
      repeat (n) i_capture_pin_source.pulse(3);
      repeat (6) @(posedge mclk);
      #1;
   endtask

   task automatic set_tb(input logic [15:0] v2, input logic [15:0] v3);
      @(posedge mclk) begin tb2_value <= v2; tb3_value <= v3; end
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      check(ctrl_q, 16'h0080);
      check(16'(status), 16'h0000);
      check(16'(irq_req), 16'h0000);
   endtask

   // Fill past four, overflow, then drain; the reader never reads when empty
   task automatic t_fifo();
      wr(16'h0083);
      for (int i = 0; i < 4; i++) begin
         set_tb(16'h5000, 16'hA000 + 16'(i));
         rise(1);
      end
      check(16'(status.capture_overflow), 16'h0000);
      set_tb(16'h5000, 16'hA0FF);
      rise(1);
      check(16'(status.capture_overflow), 16'h0001);
      rd(16'hA000);
      set_tb(16'h5000, 16'hA0EE);
      rise(1);
      rd(16'hA001);
      rd(16'hA002);
      check(16'(status.fifo_not_empty), 16'h0001);
      rd(16'hA003);
      check(16'(status.fifo_not_empty), 16'h0000);
      wr(16'h0000);
   endtask

   task automatic t_tsel();
      wr(16'h0003);
      check(ctrl_q, 16'h0003);
      set_tb(16'h5011, 16'hA011);
      rise(1);
      rd(16'h5011);
   endtask

   task automatic t_every();
      wr(16'h0061);
      set_tb(16'h5022, 16'hA022);
      clr();
      i_capture_pin_source.drive(1'b1, 6);
      #1;
      check(16'(status.channel_irq_flag), 16'h0001);
      clr();
      i_capture_pin_source.drive(1'b0, 6);
      #1;
      check(16'(status.channel_irq_flag), 16'h0001);
      rise(3);
      check(16'(status.capture_overflow), 16'h0000);
      for (int i = 0; i < 4; i++) rd(16'h5022);
      check(16'(status.fifo_not_empty), 16'h0000);
   endtask

   // Every field value: one event short leaves the flag low, the next raises it
   task automatic t_epi();
      set_tb(16'h5033, 16'hA033);
      for (int e = 0; e < 4; e++) begin
         @(posedge mclk) irq_en <= e[0];
         wr(16'h0003 + 16'(e) * 16'h0020);
         clr();
         rise(e);
         check(16'(status.channel_irq_flag), 16'h0000);
         rise(1);
         check(16'(status.channel_irq_flag), 16'h0001);
         check(16'(irq_req), 16'(e[0]));
         repeat (10) @(posedge mclk);
         check(16'(status.channel_irq_flag), 16'h0001);
         for (int i = 0; i <= e; i++) rd(16'h5033);
      end
   endtask

   task automatic t_power();
      @(posedge mclk) begin power <= '{1'b1, 1'b0}; irq_en <= 1'b1; tb2_run <= 1'b0; tb3_run <= 1'b0; end
      wr(16'h0067);
      clr();
      rise(1);
      check(16'(status.channel_irq_flag), 16'h0001);
      check(16'(wake_seen), 16'h0001);
      check(16'(status.fifo_not_empty), 16'h0000);
      wr(16'h0003);
      clr();
      rise(1);
      check(16'({status.fifo_not_empty, status.channel_irq_flag}), 16'h0000);
      wr(16'h0004);
      rise(4);
      check(16'(status.fifo_not_empty), 16'h0000);
      @(posedge mclk) begin power <= '{1'b0, 1'b1}; tb2_run <= 1'b1; end
      wr(16'h0004);
      rise(3);
      check(16'(status.fifo_not_empty), 16'h0000);
      rise(1);
      rd(16'h5033);
      wr(16'h2003);
      rise(1);
      check(16'(status.fifo_not_empty), 16'h0000);
      @(posedge mclk) tb2_run <= 1'b0;
      wr(16'h0003);
      rise(1);
      check(16'(status.fifo_not_empty), 16'h0000);
      wr(16'h0007);
      clr();
      rise(1);
      check(16'({status.fifo_not_empty, status.channel_irq_flag}), 16'h0001);
      check(16'(wake_seen), 16'h0001);
      @(posedge mclk) begin power <= '{1'b0, 1'b0}; tb2_run <= 1'b1; tb3_run <= 1'b1; end
   endtask

   // ---------------------------------------------------------------
   // Closing report and main sequence
   // ---------------------------------------------------------------
   task automatic complete_run();
      $display("Checks run %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Guard against a stalled run; running out counts as a mismatch
   initial begin
      repeat (60000) @(posedge mclk);
      failures++;
      complete_run();
   end

   initial begin
      repeat (20) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk) #1;
      t_reset();
      t_fifo();
      t_tsel();
      t_every();
      t_epi();
      t_power();
      complete_run();
   end
endmodule // tb_top
